// [verilog/fipc_pkg.sv]
package fipc_pkg;
   // Bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DEC_W  = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_RAW      = 8'h10;

   // Fault source bit positions, shared by status, raw, irq status and mask, then the status-only test-active bit
   localparam int unsigned NSRC        = 4;
   localparam int unsigned BIT_FAILURE = 0;
   localparam int unsigned BIT_OTWARN  = 1;
   localparam int unsigned BIT_GNDLOSS = 2;
   localparam int unsigned BIT_MEMFAIL = 3;
   localparam int unsigned BIT_TESTACT = 4;

   // Control register fields
   localparam int unsigned BIT_TEST    = 0;
   localparam int unsigned BIT_CLEAN   = 1;

   // Reset values
   localparam logic [3:0]  SRC_RST     = 4'h0;
   localparam logic [3:0]  MASK_RST    = 4'hF;
   localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0]  HTRANS_SEQ    = 2'b11;
   localparam logic [2:0]  HSIZE_WORD    = 3'b010;
   localparam logic        HRESP_OKAY    = 1'b0;
endpackage : fipc_pkg

// [verilog/fipc_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage leaves this module
module fipc_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   // A zero width synchroniser has nothing to carry
   if (W < 1) begin : g_bad_w
      $error("fipc_sync width must be at least one");
   end

   // Next values of both stages
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Stage registers; reset to a quiet level so no false edge follows reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= meta_d;
         sync_out <= sync_d;
      end
   end
endmodule : fipc_sync

// [verilog/fipc_sticky.sv]
`timescale 1ns/1ps
// Bank of sticky bits; a set in the clearing cycle wins so no event is lost
module fipc_sticky #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Set and clear strobes
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   // State
   output logic      [W-1:0] q
);
   logic [W-1:0] q_d;

   // A zero width bank has nothing to hold
   if (W < 1) begin : g_bad_w
      $error("fipc_sticky width must be at least one");
   end

   // Set dominates clear
   always_comb begin
      q_d = set_i | (q & ~clr_i);
   end

   // Storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= q_d;
      end
   end
endmodule : fipc_sticky

// [verilog/fipc_top.sv]
// Contract
// - Any failure, overtemp, ground loss or memory flag rising latches the pin high.
// - Software setting the test request bit drives the pin high.
// - Reading the status register clears latched fault causes of the pin.
// - Writing one to the clean command clears latched fault causes of the pin.
// - A test-raised pin stays high until the test bit is written zero.
// - The clean command removes a pin raised by the test bit only when written with the test bit zero.
`timescale 1ns/1ps
module fipc_top (
   // Clock and reset
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   // AHB-Lite slave
   input  wire logic                       hsel,
   input  wire logic [fipc_pkg::ADDR_W-1:0] haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic                       hready,
   input  wire logic [fipc_pkg::DATA_W-1:0] hwdata,
   output logic      [fipc_pkg::DATA_W-1:0] hrdata_q,
   output logic                            hreadyout_q,
   output logic                            hresp_q,
   // Monitor flags from the analog side, asynchronous levels
   input  wire logic                       failure_flag,
   input  wire logic                       overtemp_warn_flag,
   input  wire logic                       gnd_loss_flag,
   input  wire logic                       mem_fail_flag,
   // Interrupt pin toward the controller, active high
   output logic                            interrupt_pin_q,
   // Masked event interrupt, active high level
   output logic                            irq_q
);
   import fipc_pkg::*;

   logic [NSRC-1:0]   flag_raw;
   logic [NSRC-1:0]   flag_s;
   logic [NSRC-1:0]   flag_prev_q;
   logic [NSRC-1:0]   flag_rise;
   logic [NSRC-1:0]   fault_q;
   logic [NSRC-1:0]   fault_clr;
   logic [NSRC-1:0]   irq_stat_q;
   logic [NSRC-1:0]   irq_clr;
   logic [NSRC-1:0]   mask_q;
   logic [NSRC-1:0]   mask_d;
   logic              test_q;
   logic              test_d;
   logic              pin_d;
   logic              irq_d;
   logic              addr_ok;
   logic              rd_acc;
   logic              wr_acc;
   logic [DEC_W-1:0]  ofs;
   logic              wr_pend_q;
   logic              wr_pend_d;
   logic [DEC_W-1:0]  wr_ofs_q;
   logic [DEC_W-1:0]  wr_ofs_d;
   logic [DATA_W-1:0] rdata_d;
   logic              wr_ctrl;
   logic              wr_mask;
   logic              clean_cmd;
   logic              rd_status;
   logic              rd_irq;

   // Flags are pin levels from another domain
   // Two flops cost two cycles of latency but keep metastability out of the latches
   assign flag_raw[BIT_FAILURE] = failure_flag;
   assign flag_raw[BIT_OTWARN]  = overtemp_warn_flag;
   assign flag_raw[BIT_GNDLOSS] = gnd_loss_flag;
   assign flag_raw[BIT_MEMFAIL] = mem_fail_flag;

   fipc_sync #(
      .W        (NSRC)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (flag_raw),
      .sync_out (flag_s)
   );

   // A flag held high does not relatch after a clear; it has to fall first
   // Previous flag level for rising edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_prev_q <= SRC_RST;
      end else begin
         flag_prev_q <= flag_s;
      end
   end

   assign flag_rise = flag_s & ~flag_prev_q;

   // Address phase decode; only whole-word transfers are expected
   assign ofs     = haddr[DEC_W-1:0];
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign rd_acc  = addr_ok && !hwrite;
   assign wr_acc  = addr_ok && hwrite;

   // Writes land in the data phase, when hwdata is valid
   // The offset is held because hwdata trails its address by one cycle
   always_comb begin
      wr_pend_d = wr_acc;
      wr_ofs_d  = wr_acc ? ofs : wr_ofs_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q  <= '0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_ofs_q  <= wr_ofs_d;
      end
   end

   assign wr_ctrl   = wr_pend_q && (wr_ofs_q == OFS_CONTROL);
   assign wr_mask   = wr_pend_q && (wr_ofs_q == OFS_IRQ_MASK);
   assign clean_cmd = wr_ctrl && hwdata[BIT_CLEAN];
   assign rd_status = rd_acc && (ofs == OFS_STATUS);
   assign rd_irq    = rd_acc && (ofs == OFS_IRQ_STAT);

   // Status read and clean command drop latched fault causes
   assign fault_clr = (rd_status || clean_cmd) ? ~SRC_RST : SRC_RST;

   fipc_sticky #(
      .W        (NSRC)
   ) u_fault (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .set_i    (flag_rise),
      .clr_i    (fault_clr),
      .q        (fault_q)
   );

   // Reading the event status clears it; a new event in that cycle survives
   assign irq_clr = rd_irq ? ~SRC_RST : SRC_RST;

   fipc_sticky #(
      .W        (NSRC)
   ) u_irq (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .set_i    (flag_rise),
      .clr_i    (irq_clr),
      .q        (irq_stat_q)
   );

   // Control and mask next values
   always_comb begin
      test_d = test_q;
      mask_d = mask_q;
      // Test bit changes only by a write of the control register
      if (wr_ctrl) begin
         test_d = hwdata[BIT_TEST];
      end
      if (wr_mask) begin
         mask_d = hwdata[NSRC-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         test_q <= 1'b0;
         mask_q <= MASK_RST;
      end else begin
         test_q <= test_d;
         mask_q <= mask_d;
      end
   end

   // Read data is captured at the address phase, shown in the data phase
   // Unmapped offsets read zero so a probe of the map sees no stale data
   always_comb begin
      rdata_d = '0;
      if (rd_acc) begin
         unique case (ofs)
            OFS_STATUS: begin
               rdata_d[NSRC-1:0]   = fault_q;
               rdata_d[BIT_TESTACT] = test_q;
            end
            OFS_CONTROL: begin
               rdata_d[BIT_TEST] = test_q;
            end
            OFS_IRQ_STAT: begin
               rdata_d[NSRC-1:0] = irq_stat_q;
            end
            OFS_IRQ_MASK: begin
               rdata_d[NSRC-1:0] = mask_q;
            end
            OFS_RAW: begin
               rdata_d[NSRC-1:0] = flag_s;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   // Pin and interrupt next values
   always_comb begin
      // Latched causes or test request hold the pin
      pin_d = (|fault_q) || test_q;
      irq_d = |(irq_stat_q & mask_q);
   end

   // Output registers; zero wait states so hreadyout stays high
   // Every output is a register so the pin never shows decode glitches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_pin_q <= 1'b0;
         irq_q           <= 1'b0;
         hrdata_q        <= RDATA_RST;
         hreadyout_q     <= 1'b1;
         hresp_q         <= HRESP_OKAY;
      end else begin
         interrupt_pin_q <= pin_d;
         irq_q           <= irq_d;
         hrdata_q        <= rdata_d;
         hreadyout_q     <= 1'b1;
         hresp_q         <= HRESP_OKAY;
      end
   end

   // Helper: marks the first cycle after reset release
   logic out_of_reset_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_of_reset_q <= 1'b0;
      end else begin
         out_of_reset_q <= 1'b1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_flag_sets_pin: assert property (|flag_rise |-> ##2 interrupt_pin_q)
      else $error("flag edge did not raise pin");
   a_test_raises_pin: assert property (wr_ctrl && hwdata[BIT_TEST] |-> ##2 interrupt_pin_q)
      else $error("test request did not raise pin");
   a_read_clears: assert property (rd_status && !(|flag_rise) |=> fault_q == SRC_RST)
      else $error("status read left fault latched");
   a_clean_clears: assert property (clean_cmd && !(|flag_rise) |=> fault_q == SRC_RST)
      else $error("clean command left fault latched");
   // Test pin held until test bit written zero
   a_test_holds: assert property (test_q && !wr_ctrl |=> test_q ##1 interrupt_pin_q)
      else $error("test interrupt released early");
   // Release once nothing holds the pin
   a_pin_release: assert property (fault_q == SRC_RST && !test_q |=> !interrupt_pin_q)
      else $error("pin stuck high without cause");
   a_clean_keeps_test: assert property (clean_cmd && hwdata[BIT_TEST] |=> test_q ##1 interrupt_pin_q)
      else $error("clean removed test interrupt");
   a_reset_low: assert property (!out_of_reset_q |-> !interrupt_pin_q && fault_q == SRC_RST)
      else $error("pin not low after reset");
   // Unmasked events raise the irq output
   a_irq_level: assert property ((irq_stat_q & mask_q) != SRC_RST |=> irq_q)
      else $error("unmasked event without irq");
   // Bus answers always ready and OKAY
   a_bus_okay: assert property (hreadyout_q && hresp_q == HRESP_OKAY)
      else $error("bus response not ready or not okay");
   // Test bit cleared lets the pin fall
   a_test_release: assert property (wr_ctrl && !hwdata[BIT_TEST]
      && fault_q == SRC_RST && !(|flag_rise) |=> ##1 !interrupt_pin_q)
      else $error("pin held after test bit cleared");
   // Zero write drops the test bit
   a_test_write_zero: assert property (wr_ctrl && !hwdata[BIT_TEST] |=> !test_q)
      else $error("test bit kept after zero write");
   // Pin high only with a cause
   a_pin_has_cause: assert property (interrupt_pin_q |-> $past(fault_q) != SRC_RST || $past(test_q))
      else $error("pin high without cause");
   // Latch sets only on a flag edge
   a_latch_needs_edge: assert property (fault_q == SRC_RST && !(|flag_rise) |=> fault_q == SRC_RST)
      else $error("fault latch set without flag edge");
   // Status read shows the test bit
   a_status_test_bit: assert property (rd_status |=> hrdata_q[BIT_TESTACT] == $past(test_q))
      else $error("status read hides test bit");
   // Event status read clears it
   a_irq_read_clears: assert property (rd_irq && !(|flag_rise) |=> irq_stat_q == SRC_RST)
      else $error("event status read left bits set");
   // No unmasked event, no irq
   a_irq_quiet: assert property ((irq_stat_q & mask_q) == SRC_RST |=> !irq_q)
      else $error("irq high without unmasked event");
   // Mask takes the written value
   a_mask_write: assert property (wr_mask |=> mask_q == NSRC'($past(hwdata)))
      else $error("mask write lost");
   // Read data rests at zero outside reads
   a_rdata_idle: assert property (!rd_acc |=> hrdata_q == RDATA_RST)
      else $error("read data not zero outside a read");

   c_fault_then_read: cover property (interrupt_pin_q && !test_q ##1 rd_status ##2 !interrupt_pin_q);
   c_fault_then_clean: cover property (interrupt_pin_q && !test_q ##1 clean_cmd ##2 !interrupt_pin_q);
   c_test_and_clean: cover property (test_q && clean_cmd ##2 interrupt_pin_q);
   c_irq_raised: cover property ($rose(irq_q));
endmodule : fipc_top

// [verification/fipc_mcu_model.sv]
`timescale 1ns/1ps
// Controller side of the block: a single-transfer AHB-Lite master
module fipc_mcu_model (
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // AHB-Lite master
   output logic                             hsel,
   output logic [fipc_pkg::ADDR_W-1:0]      haddr,
   output logic [1:0]                       htrans,
   output logic                             hwrite,
   output logic [2:0]                       hsize,
   output logic [fipc_pkg::DATA_W-1:0]      hwdata,
   input  wire logic                        hready,
   input  wire logic [fipc_pkg::DATA_W-1:0] hrdata,
   input  wire logic                        hresp
);
   import fipc_pkg::*;

   int unsigned n_timeout;
   int unsigned n_bad_resp;

   // Bus idle at time zero so the slave never sees a stray request
   initial begin
      n_timeout = 0;
      n_bad_resp = 0;
      hsel      = 1'b0;
      haddr     = 32'h0000_0000;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = HSIZE_WORD;
      hwdata    = 32'h0000_0000;
   end

   // Bounded wait for hready at a rising edge; a stuck slave is counted, not hung on
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 100) begin
         @(posedge hclk);
         n++;
      end
      if (hready !== 1'b1) n_timeout++;
      // Any response other than OKAY is counted as a bus error
      if (hready === 1'b1 && hresp !== HRESP_OKAY) n_bad_resp++;
   endtask : wait_ready

   // One whole-word transfer; gap idles first to model a slow controller
   task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       input int unsigned gap, output logic [31:0] rd);
      repeat (gap) @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, ofs};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
endmodule : fipc_mcu_model

// [verification/tb_fipc_top.sv]
`timescale 1ns/1ps
module tb_fipc_top;
   import fipc_pkg::*;

   logic        hclk;
   logic        hresetn;
   logic [3:0]  flags;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata_q;
   logic        hreadyout_q;
   logic        hresp_q;
   logic        interrupt_pin_q;
   logic        irq_q;
   logic [31:0] rd;
   int          n_mismatch;
   int          checked;

   // The one slave's hreadyout is the bus hready
   fipc_top dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout_q), .hwdata(hwdata),
      .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
      .failure_flag(flags[BIT_FAILURE]), .overtemp_warn_flag(flags[BIT_OTWARN]),
      .gnd_loss_flag(flags[BIT_GNDLOSS]), .mem_fail_flag(flags[BIT_MEMFAIL]),
      .interrupt_pin_q(interrupt_pin_q), .irq_q(irq_q)
   );

   fipc_mcu_model u_mcu (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_q),
      .hrdata(hrdata_q), .hresp(hresp_q)
   );

   // 250 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic summarize();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // A bus timeout in the master ends the run as a failure
   task automatic guard();
      if (u_mcu.n_timeout != 0 || u_mcu.n_bad_resp != 0) begin
         n_mismatch++;
         summarize();
      end
   endtask : guard

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
      u_mcu.xfer(1'b0, ofs, 32'h0, 0, rd);
      guard();
      check(rd, exp);
      check({31'h0, hresp_q}, 32'h0);
   endtask : rd_chk

   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      u_mcu.xfer(1'b1, ofs, wd, 1, rd);
      guard();
   endtask : wr

   // Pin and irq packed side by side for one compare
   function automatic logic [31:0] pins();
      return {30'h0, interrupt_pin_q, irq_q};
   endfunction : pins

   initial begin
      n_mismatch = 0;
      checked    = 0;
      hresetn    = 1'b0;
      flags      = 4'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      check(pins(), 32'h0);
      check({31'h0, hreadyout_q}, 32'h1);
      check({31'h0, hresp_q}, 32'h0);
      cyc(1);
      // Each fault source latches the pin and is cleared by a status read
      for (int i = 0; i < NSRC; i++) begin
         flags[i] <= 1'b1;
         cyc(6);
         check(pins(), 32'h3);
         rd_chk(OFS_RAW, 32'h1 << i);
         rd_chk(OFS_STATUS, 32'h1 << i);
         rd_chk(OFS_IRQ_STAT, 32'h1 << i);
         cyc(2);
         check(pins(), 32'h0);
         flags[i] <= 1'b0;
         cyc(4);
      end
      // Masked source still raises the pin; clean command drops it
      wr(OFS_IRQ_MASK, 32'h0);
      flags[BIT_GNDLOSS] <= 1'b1;
      cyc(6);
      check(pins(), 32'h2);
      rd_chk(OFS_IRQ_MASK, 32'h0);
      wr(OFS_CONTROL, 32'h2);
      cyc(2);
      check(pins(), 32'h0);
      rd_chk(OFS_CONTROL, 32'h0);
      wr(OFS_IRQ_MASK, 32'hF);
      cyc(3);
      check(pins(), 32'h1);
      rd_chk(OFS_IRQ_STAT, 32'h4);
      cyc(3);
      check(pins(), 32'h0);
      flags <= 4'h0;
      // Test request holds the pin; clean cannot remove it, only a zero write
      wr(OFS_CONTROL, 32'h1);
      cyc(2);
      check(pins(), 32'h2);
      rd_chk(OFS_STATUS, 32'h10);
      wr(OFS_CONTROL, 32'h3);
      cyc(8);
      check(pins(), 32'h2);
      rd_chk(OFS_CONTROL, 32'h1);
      wr(OFS_CONTROL, 32'h0);
      cyc(2);
      check(pins(), 32'h0);
      // Unmapped space reads zero and ignores writes
      wr(8'h24, 32'hFFFF_FFFF);
      rd_chk(8'h20, 32'h0);
      check(pins(), 32'h0);
      // Reset in mid-run while the test request holds the pin
      wr(OFS_CONTROL, 32'h1);
      cyc(2);
      hresetn <= 1'b0;
      cyc(2);
      check(pins(), 32'h0);
      hresetn <= 1'b1;
      cyc(2);
      check(pins(), 32'h0);
      rd_chk(OFS_CONTROL, 32'h0);
      summarize();
   end
endmodule : tb_fipc_top
